// ---- csx_map.vh ----
`ifndef CSX_MAP_VH
`define CSX_MAP_VH

// Register byte offsets.
`define CSX_OFF_MODE 8'h00
`define CSX_OFF_CTRL 8'h04
`define CSX_OFF_STATUS 8'h08
`define CSX_OFF_TGT_POS 8'h0c
`define CSX_OFF_TGT_VEL 8'h10
`define CSX_OFF_TGT_TRQ 8'h14
`define CSX_OFF_POS_OFS 8'h18
`define CSX_OFF_VEL_OFS 8'h1c
`define CSX_OFF_TRQ_OFS 8'h20
`define CSX_OFF_LIM_MIN 8'h24
`define CSX_OFF_LIM_MAX 8'h28
`define CSX_OFF_RANGE 8'h2c
`define CSX_OFF_FE_WIN 8'h30
`define CSX_OFF_FE_TMO 8'h34
`define CSX_OFF_QS_DEC 8'h38
`define CSX_OFF_QS_OPT 8'h3c
`define CSX_OFF_MAX_SPD 8'h40
`define CSX_OFF_IP_PER 8'h44
`define CSX_OFF_IP_IDX 8'h48
`define CSX_OFF_ACT_POS 8'h4c
`define CSX_OFF_ACT_VEL 8'h50
`define CSX_OFF_FE_ACT 8'h54
`define CSX_OFF_DEM_POS 8'h58
`define CSX_OFF_DEM_VEL 8'h5c
`define CSX_OFF_DEM_TRQ 8'h60

// Mode codes and the only accepted time index.
`define CSX_MODE_CSP 8'h08
`define CSX_MODE_CSV 8'h09
`define CSX_IP_IDX_MS 8'hfd

// Control register fields.
`define CSX_CTRL_OPER 0
`define CSX_CTRL_QSTOP 1
`define CSX_CTRL_CLOOP 2

// Status word fields.
`define CSX_ST_SYNC 8
`define CSX_ST_LIMIT 11
`define CSX_ST_FOLLOW 12
`define CSX_ST_FERR 13

// Reset values.
`define CSX_RST_IP_PER 32'h0000_0001
`define CSX_RST_LIM_MIN 32'h8000_0000
`define CSX_RST_LIM_MAX 32'h7fff_ffff
`define CSX_RST_MAX_SPD 32'h7fff_ffff

// Time base: 1 ms at a 4 ns clock.
`define CSX_TB_US 1000
`define CSX_CLK_PS 4000
`define CSX_MS_CYCLES ((`CSX_TB_US * 1000000) / `CSX_CLK_PS)

`endif

// ---- csx_top.v ----
`timescale 1ns/10ps
`include "csx_map.vh"

module csx_top #(
  parameter MS_CYCLES = `CSX_MS_CYCLES
) (
  // APB slave.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Fieldbus and feedback, same clock domain.
  input wire sync_pulse,
  input wire [31:0] act_pos,
  input wire [31:0] act_vel,
  // Demands to the control loops.
  output reg [31:0] dem_pos_q,
  output reg [31:0] dem_vel_q,
  output reg [31:0] dem_trq_q,
  output reg cycle_strobe_q,
  output reg drive_en_q,
  output reg [15:0] status_q
);

  // Signed clamp shared by the limit, step and speed paths.
  function [31:0] csx_sat;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    begin
      if ($signed(v) < $signed(lo)) begin
        csx_sat = lo;
      end else if ($signed(v) > $signed(hi)) begin
        csx_sat = hi;
      end else begin
        csx_sat = v;
      end
    end
  endfunction

  // Magnitude of a signed value; the most negative value maps onto itself.
  function [31:0] csx_abs;
    input [31:0] v;
    begin
      csx_abs = v[31] ? (32'h0000_0000 - v) : v;
    end
  endfunction

  // Configuration written over the bus, then the internal timing state.
  reg [7:0] mode_q;
  reg [2:0] ctrl_q;
  reg [31:0] tgt_pos_q, tgt_vel_q, tgt_trq_q;
  reg [31:0] pos_ofs_q, vel_ofs_q, trq_ofs_q;
  reg [31:0] lim_min_q, lim_max_q;
  reg range_q;
  reg [31:0] fe_win_q, fe_tmo_q, qs_dec_q;
  reg [15:0] qs_opt_q;
  reg [31:0] max_spd_q, ip_per_q;
  reg [7:0] ip_idx_q;
  reg [31:0] act_pos_q, act_vel_q, fe_act_q;
  reg [31:0] tick_cnt_q;
  reg ms_tick_q;
  reg [31:0] ms_cnt_q;
  reg [31:0] since_sync_q;
  reg in_sync_q;
  reg [31:0] fe_cnt_q;
  reg qs_done_q;

  wire oper = ctrl_q[`CSX_CTRL_OPER];
  wire qstop = ctrl_q[`CSX_CTRL_QSTOP];
  wire cloop = ctrl_q[`CSX_CTRL_CLOOP];
  wire csp = (mode_q == `CSX_MODE_CSP);
  wire csv = (mode_q == `CSX_MODE_CSV);
  wire follow = (csp | csv) & oper & ~qstop;
  // A write commits only in the access cycle in which the slave's own ready stands.
  wire wr_en = psel & penable & pready & pwrite;
  wire [31:0] neg_max = 32'h0000_0000 - max_spd_q;

  // With SYNC locked the cycle follows SYNC, otherwise the internal period.
  wire ms_cycle = ms_tick_q & (ms_cnt_q >= ip_per_q - 32'h0000_0001);
  wire cycle = in_sync_q ? (sync_pulse & oper) : ms_cycle;

  wire [31:0] pos_raw = tgt_pos_q + pos_ofs_q;
  wire pos_over = ($signed(pos_raw) > $signed(lim_max_q)) | ($signed(pos_raw) < $signed(lim_min_q));
  wire [31:0] pos_lim = csx_sat(pos_raw, lim_min_q, lim_max_q);
  wire [31:0] pos_step = pos_lim - dem_pos_q;
  wire [31:0] pos_cl = csx_sat(pos_step, neg_max, max_spd_q) + dem_pos_q;
  wire [31:0] vel_raw = tgt_vel_q + vel_ofs_q;
  wire [31:0] vel_lim = csx_sat(vel_raw, neg_max, max_spd_q);
  wire [31:0] fe_now = dem_pos_q - act_pos_q;
  wire fe_out = csx_abs(fe_now) > fe_win_q;

  reg [31:0] rd_d;
  reg rd_err_d;
  always @* begin
    rd_d = 32'h0000_0000;
    rd_err_d = 1'b0;
    case (paddr)
      `CSX_OFF_MODE: rd_d = {24'h00_0000, mode_q};
      `CSX_OFF_CTRL: rd_d = {29'h0000_0000, ctrl_q};
      `CSX_OFF_STATUS: rd_d = {16'h0000, status_q};
      `CSX_OFF_TGT_POS: rd_d = tgt_pos_q;
      `CSX_OFF_TGT_VEL: rd_d = tgt_vel_q;
      `CSX_OFF_TGT_TRQ: rd_d = tgt_trq_q;
      `CSX_OFF_POS_OFS: rd_d = pos_ofs_q;
      `CSX_OFF_VEL_OFS: rd_d = vel_ofs_q;
      `CSX_OFF_TRQ_OFS: rd_d = trq_ofs_q;
      `CSX_OFF_LIM_MIN: rd_d = lim_min_q;
      `CSX_OFF_LIM_MAX: rd_d = lim_max_q;
      `CSX_OFF_RANGE: rd_d = {31'h0000_0000, range_q};
      `CSX_OFF_FE_WIN: rd_d = fe_win_q;
      `CSX_OFF_FE_TMO: rd_d = fe_tmo_q;
      `CSX_OFF_QS_DEC: rd_d = qs_dec_q;
      `CSX_OFF_QS_OPT: rd_d = {16'h0000, qs_opt_q};
      `CSX_OFF_MAX_SPD: rd_d = max_spd_q;
      `CSX_OFF_IP_PER: rd_d = ip_per_q;
      `CSX_OFF_IP_IDX: rd_d = {{24{ip_idx_q[7]}}, ip_idx_q};
      `CSX_OFF_ACT_POS: rd_d = act_pos_q;
      `CSX_OFF_ACT_VEL: rd_d = act_vel_q;
      `CSX_OFF_FE_ACT: rd_d = fe_act_q;
      `CSX_OFF_DEM_POS: rd_d = dem_pos_q;
      `CSX_OFF_DEM_VEL: rd_d = dem_vel_q;
      `CSX_OFF_DEM_TRQ: rd_d = dem_trq_q;
      default: rd_err_d = 1'b1;
    endcase
  end

  // The answer comes one cycle after setup so read data can leave from a flop.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
      pslverr <= rd_err_d;
      pready <= 1'b1;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes; targets are absolute, so a rewrite just overwrites.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 8'h00;
      ctrl_q <= 3'h0;
      tgt_pos_q <= 32'h0000_0000;
      tgt_vel_q <= 32'h0000_0000;
      tgt_trq_q <= 32'h0000_0000;
      pos_ofs_q <= 32'h0000_0000;
      vel_ofs_q <= 32'h0000_0000;
      trq_ofs_q <= 32'h0000_0000;
      lim_min_q <= `CSX_RST_LIM_MIN;
      lim_max_q <= `CSX_RST_LIM_MAX;
      range_q <= 1'b0;
      fe_win_q <= 32'h0000_0000;
      fe_tmo_q <= 32'h0000_0000;
      qs_dec_q <= 32'h0000_0000;
      qs_opt_q <= 16'h0000;
      max_spd_q <= `CSX_RST_MAX_SPD;
      ip_per_q <= `CSX_RST_IP_PER;
      ip_idx_q <= `CSX_IP_IDX_MS;
    end else if (wr_en) begin
      case (paddr)
        `CSX_OFF_MODE: mode_q <= pwdata[7:0];
        `CSX_OFF_CTRL: ctrl_q <= pwdata[2:0];
        `CSX_OFF_TGT_POS: tgt_pos_q <= pwdata;
        `CSX_OFF_TGT_VEL: tgt_vel_q <= pwdata;
        `CSX_OFF_TGT_TRQ: tgt_trq_q <= pwdata;
        `CSX_OFF_POS_OFS: pos_ofs_q <= pwdata;
        `CSX_OFF_VEL_OFS: vel_ofs_q <= pwdata;
        `CSX_OFF_TRQ_OFS: trq_ofs_q <= pwdata;
        `CSX_OFF_LIM_MIN: lim_min_q <= pwdata;
        `CSX_OFF_LIM_MAX: lim_max_q <= pwdata;
        `CSX_OFF_RANGE: range_q <= pwdata[0];
        `CSX_OFF_FE_WIN: fe_win_q <= pwdata;
        `CSX_OFF_FE_TMO: fe_tmo_q <= pwdata;
        `CSX_OFF_QS_DEC: qs_dec_q <= pwdata;
        `CSX_OFF_QS_OPT: qs_opt_q <= pwdata[15:0];
        `CSX_OFF_MAX_SPD: max_spd_q <= pwdata;
        `CSX_OFF_IP_PER: ip_per_q <= (pwdata == 32'h0000_0000) ? `CSX_RST_IP_PER : pwdata;
        `CSX_OFF_IP_IDX: begin
          // Any other time base is refused and the old index kept.
          if (pwdata[7:0] == `CSX_IP_IDX_MS) begin
            ip_idx_q <= pwdata[7:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Millisecond time base; the cycle is the period in ms at index -3.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      ms_tick_q <= 1'b0;
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_tick_q <= (tick_cnt_q == MS_CYCLES - 1);
      tick_cnt_q <= (tick_cnt_q == MS_CYCLES - 1) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (cycle) begin
        ms_cnt_q <= 32'h0000_0000;
      end else if (ms_tick_q) begin
        ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Locked when a SYNC lands within one ms of the period; lost on an early SYNC or once a SYNC is more than one ms overdue.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_sync_q <= 32'h0000_0000;
      in_sync_q <= 1'b0;
    end else if (!oper) begin
      since_sync_q <= 32'h0000_0000;
      in_sync_q <= 1'b0;
    end else if (sync_pulse) begin
      since_sync_q <= 32'h0000_0000;
      in_sync_q <= (since_sync_q + 32'h0000_0001 >= ip_per_q) & (since_sync_q <= ip_per_q + 32'h0000_0001);
    end else if (ms_tick_q) begin
      since_sync_q <= since_sync_q + 32'h0000_0001;
      if (since_sync_q > ip_per_q + 32'h0000_0001) begin
        in_sync_q <= 1'b0;
      end
    end
  end

  // Set values are taken each cycle with no handshake bit; with the closed loop bit the position step is clamped to the maximum speed.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dem_pos_q <= 32'h0000_0000;
      dem_vel_q <= 32'h0000_0000;
      dem_trq_q <= 32'h0000_0000;
      cycle_strobe_q <= 1'b0;
      drive_en_q <= 1'b0;
      qs_done_q <= 1'b0;
    end else begin
      cycle_strobe_q <= cycle & follow;
      if (follow) begin
        drive_en_q <= 1'b1;
        qs_done_q <= 1'b0;
        if (cycle) begin
          dem_trq_q <= tgt_trq_q + trq_ofs_q;
          if (csp) begin
            // Range mode 1 holds the last demand on overrun instead of clamping.
            if (!(range_q & pos_over)) begin
              dem_pos_q <= cloop ? csx_sat(pos_cl, lim_min_q, lim_max_q) : pos_lim;
            end
            dem_vel_q <= 32'h0000_0000;
          end else begin
            dem_vel_q <= vel_lim;
          end
        end
      end else if (qstop & (csp | csv)) begin
        // Option 0 drops the drive at once; 1 and 2 ramp then disable; others ramp and hold.
        if (qs_opt_q == 16'h0000) begin
          drive_en_q <= 1'b0;
          dem_vel_q <= 32'h0000_0000;
        end else if (ms_tick_q & ~qs_done_q) begin
          if (csx_abs(dem_vel_q) <= qs_dec_q) begin
            dem_vel_q <= 32'h0000_0000;
            qs_done_q <= 1'b1;
          end else begin
            dem_vel_q <= dem_vel_q[31] ? dem_vel_q + qs_dec_q : dem_vel_q - qs_dec_q;
          end
        end else if (qs_done_q & (qs_opt_q <= 16'h0002)) begin
          drive_en_q <= 1'b0;
        end
      end else begin
        drive_en_q <= 1'b0;
        dem_vel_q <= 32'h0000_0000;
      end
    end
  end

  // Following error, counted in ms and restarted when back in the window.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_pos_q <= 32'h0000_0000;
      act_vel_q <= 32'h0000_0000;
      fe_act_q <= 32'h0000_0000;
      fe_cnt_q <= 32'h0000_0000;
    end else begin
      act_pos_q <= act_pos;
      act_vel_q <= act_vel;
      fe_act_q <= fe_now;
      if (!(csp & follow) | !fe_out) begin
        fe_cnt_q <= 32'h0000_0000;
      end else if (ms_tick_q & (fe_cnt_q <= fe_tmo_q)) begin
        fe_cnt_q <= fe_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Status bits lag their sources by one clock.
  // The error bit is gated by following, so it never stands without bit 12.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= 16'h0000;
      status_q[`CSX_ST_SYNC] <= in_sync_q;
      status_q[`CSX_ST_LIMIT] <= csp & pos_over;
      status_q[`CSX_ST_FOLLOW] <= follow;
      status_q[`CSX_ST_FERR] <= csp & follow & (fe_cnt_q > fe_tmo_q);
    end
  end

endmodule

// ---- csx_properties.sv ----
`timescale 1ns/10ps
module csx_properties #(
  parameter MS_CYCLES = 10
) (
  // APB side.
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Motion side.
  input wire sync_pulse,
  input wire [31:0] act_pos,
  input wire [31:0] act_vel,
  input wire [31:0] dem_pos_q,
  input wire [31:0] dem_vel_q,
  input wire [31:0] dem_trq_q,
  input wire cycle_strobe_q,
  input wire drive_en_q,
  input wire [15:0] status_q
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (s_answer |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_reserved: assert property ((status_q & 16'hc6ff) == 16'h0000)
    else $error("reserved status bit set");
  a_strobe_single: assert property (cycle_strobe_q |=> !cycle_strobe_q)
    else $error("cycle strobe longer than one cycle");
  a_pos_hold: assert property ($changed(dem_pos_q) |-> cycle_strobe_q)
    else $error("demand position moved between cycles");
  a_ferr_follow: assert property (status_q[13] |-> status_q[12])
    else $error("following error while not following");
  a_follow_enabled: assert property (status_q[12] |-> drive_en_q)
    else $error("following while drive disabled");
endmodule

bind csx_top csx_properties #(.MS_CYCLES(MS_CYCLES)) csx_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sync_pulse(sync_pulse), .act_pos(act_pos), .act_vel(act_vel), .dem_pos_q(dem_pos_q),
  .dem_vel_q(dem_vel_q), .dem_trq_q(dem_trq_q), .cycle_strobe_q(cycle_strobe_q),
  .drive_en_q(drive_en_q), .status_q(status_q));

// ---- csx_sync_master.sv ----
`timescale 1ns/10ps
module csx_sync_master (
  // Clock and control.
  input wire pclk,
  input wire presetn,
  input wire en,
  input wire [7:0] gap,
  // Fieldbus event.
  output reg sync_pulse
);
  reg [7:0] cnt_q;
  // A fixed spacing is what lets the drive lock; jitter would defeat it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      sync_pulse <= 1'b0;
    end else begin
      sync_pulse <= en && (cnt_q == 8'h00);
      cnt_q <= (!en || cnt_q == gap - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

// ---- cyclic_sync_position_velocity_test.sv ----
`timescale 1ns/10ps
`include "csx_map.vh"
module cyclic_sync_position_velocity_test;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] act_pos = 32'h0;
  reg [31:0] act_vel = 32'h0;
  reg sync_en = 1'b0;
  wire [31:0] prdata, dem_pos_q, dem_vel_q, dem_trq_q;
  wire pready, pslverr, sync_pulse, cycle_strobe_q, drive_en_q;
  wire [15:0] status_q;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer m;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] t, o, v, av;

  always #2 pclk = ~pclk;

  csx_top #(.MS_CYCLES(10)) csx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sync_pulse(sync_pulse), .act_pos(act_pos),
    .act_vel(act_vel), .dem_pos_q(dem_pos_q), .dem_vel_q(dem_vel_q), .dem_trq_q(dem_trq_q),
    .cycle_strobe_q(cycle_strobe_q), .drive_en_q(drive_en_q), .status_q(status_q));
  csx_sync_master csx_sync_master_inst (.pclk(pclk), .presetn(presetn), .en(sync_en),
    .gap(8'h0a), .sync_pulse(sync_pulse));

  task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task give_verdict;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task timeout;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n == 20) timeout;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic err, input logic [31:0] d);
    exp_q.push_back({err, d});
    apb(1'b0, a, 32'h0);
  endtask

  task strobes(input integer k);
    integer n;
    repeat (k) begin
      n = 0;
      @(posedge pclk);
      while (cycle_strobe_q !== 1'b1 && n < 100) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 100) timeout;
    end
  endtask

  // Read results are matched in order; on an error only the error flag counts.
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      check("read", {pslverr, e[32] ? 32'h0 : prdata}, e);
    end
  end

  initial begin
    void'($urandom(32'h888f953b));
    t = $urandom_range(1000);
    o = 2 + $urandom_range(98);
    av = $urandom;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    act_vel <= av;
    act_pos <= t + o;
    rd(`CSX_OFF_IP_PER, 1'b0, 32'h1);
    rd(`CSX_OFF_IP_IDX, 1'b0, 32'hfffffffd);
    rd(`CSX_OFF_LIM_MIN, 1'b0, 32'h80000000);
    rd(`CSX_OFF_MAX_SPD, 1'b0, 32'h7fffffff);
    rd(8'h80, 1'b1, 32'h0);
    wr(`CSX_OFF_IP_IDX, 32'h0);
    rd(`CSX_OFF_IP_IDX, 1'b0, 32'hfffffffd);
    wr(`CSX_OFF_IP_PER, 32'h0);
    rd(`CSX_OFF_IP_PER, 1'b0, 32'h1);
    wr(`CSX_OFF_FE_WIN, 32'h7fffffff);
    wr(`CSX_OFF_MODE, 32'h8);
    wr(`CSX_OFF_POS_OFS, o);
    wr(`CSX_OFF_TGT_POS, t + 7);
    wr(`CSX_OFF_TGT_POS, t);
    wr(`CSX_OFF_CTRL, 32'h11);
    strobes(2);
    rd(`CSX_OFF_DEM_POS, 1'b0, t + o);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h1000);
    rd(`CSX_OFF_ACT_POS, 1'b0, t + o);
    rd(`CSX_OFF_ACT_VEL, 1'b0, av);
    wr(`CSX_OFF_LIM_MAX, t);
    strobes(2);
    rd(`CSX_OFF_DEM_POS, 1'b0, t);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h1800);
    wr(`CSX_OFF_RANGE, 32'h1);
    wr(`CSX_OFF_LIM_MAX, t + o - 1);
    strobes(2);
    rd(`CSX_OFF_DEM_POS, 1'b0, t);
    wr(`CSX_OFF_LIM_MAX, 32'h7fffffff);
    wr(`CSX_OFF_RANGE, 32'h0);
    strobes(2);
    wr(`CSX_OFF_FE_WIN, 32'h5);
    wr(`CSX_OFF_FE_TMO, 32'h2);
    // Two short excursions must not add up once the position came back inside.
    act_pos <= t + o + 6;
    repeat (18) @(posedge pclk);
    act_pos <= t + o;
    repeat (2) @(posedge pclk);
    act_pos <= t + o - 6;
    repeat (18) @(posedge pclk);
    act_pos <= t + o;
    rd(`CSX_OFF_STATUS, 1'b0, 32'h1000);
    act_pos <= t + o + 6;
    repeat (60) @(posedge pclk);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h3000);
    act_pos <= t + o;
    repeat (5) @(posedge pclk);
    sync_en <= 1'b1;
    repeat (60) @(posedge pclk);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h1100);
    wr(`CSX_OFF_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h0);
    sync_en <= 1'b0;
    wr(`CSX_OFF_CTRL, 32'h1);
    for (m = 6; m < 11; m = m + 1) begin
      wr(`CSX_OFF_MODE, m);
      rd(`CSX_OFF_STATUS, 1'b0, (m == 8 || m == 9) ? 32'h1000 : 32'h0);
    end
    v = 1 + $urandom_range(499);
    wr(`CSX_OFF_MODE, 32'h9);
    wr(`CSX_OFF_VEL_OFS, 32'h3);
    wr(`CSX_OFF_TGT_VEL, v);
    wr(`CSX_OFF_TRQ_OFS, 32'h4);
    wr(`CSX_OFF_TGT_TRQ, 32'h14);
    strobes(2);
    rd(`CSX_OFF_DEM_VEL, 1'b0, v + 3);
    rd(`CSX_OFF_DEM_TRQ, 1'b0, 32'h18);
    wr(`CSX_OFF_MAX_SPD, v);
    strobes(2);
    rd(`CSX_OFF_DEM_VEL, 1'b0, v);
    check("drive_en", {32'h0, drive_en_q}, 33'h1);
    wr(`CSX_OFF_QS_OPT, 32'h0);
    wr(`CSX_OFF_CTRL, 32'h3);
    rd(`CSX_OFF_DEM_VEL, 1'b0, 32'h0);
    rd(`CSX_OFF_STATUS, 1'b0, 32'h0);
    check("drive_en", {32'h0, drive_en_q}, 33'h0);
    // Ramp to standstill, hold enabled with a keep-enabled option, then drop with option 1.
    wr(`CSX_OFF_CTRL, 32'h1);
    strobes(2);
    rd(`CSX_OFF_DEM_VEL, 1'b0, v);
    wr(`CSX_OFF_QS_DEC, 32'h40);
    wr(`CSX_OFF_QS_OPT, 32'h5);
    wr(`CSX_OFF_CTRL, 32'h3);
    repeat (120) @(posedge pclk);
    rd(`CSX_OFF_DEM_VEL, 1'b0, 32'h0);
    check("drive_en", {32'h0, drive_en_q}, 33'h1);
    wr(`CSX_OFF_QS_OPT, 32'h1);
    repeat (2) @(posedge pclk);
    check("drive_en", {32'h0, drive_en_q}, 33'h0);
    // Closed loop limits the position step per cycle to the maximum speed.
    wr(`CSX_OFF_MODE, 32'h8);
    wr(`CSX_OFF_MAX_SPD, 32'h3);
    wr(`CSX_OFF_TGT_POS, t + 10);
    wr(`CSX_OFF_CTRL, 32'h5);
    strobes(1);
    check("dem_pos", {1'b0, dem_pos_q}, {1'b0, t + o + 3});
    check("strobe", {32'h0, cycle_strobe_q}, 33'h1);
    give_verdict;
  end
endmodule
